/* core/ebrf_block_memory.sv */
`timescale 1ns/10ps
module ebrf_block_memory #(
    parameter bit ASYNC_LATCH_CLEAR = 1'b0
) (
    input  wire logic                    i_mclk,
    input  wire logic                    i_rst,
    input  wire logic                    i_ce,
    input  wire ebrf_pkg::ebrf_cfg_t     i_cfg,
    input  wire ebrf_pkg::ebrf_port_req_t i_port_a,
    input  wire ebrf_pkg::ebrf_port_req_t i_port_b,
    input  wire logic                    i_port_a_latch_clear,
    input  wire logic                    i_port_b_latch_clear,
    input  wire ebrf_pkg::ebrf_push_req_t i_push,
    input  wire ebrf_pkg::ebrf_pop_req_t i_pop,
    input  wire ebrf_pkg::ebrf_levels_t  i_levels,
    input  wire logic                    i_global_reset,
    input  wire logic                    i_read_pointer_rewind,
    output logic [ebrf_pkg::DATA_W-1:0]  o_a_rdata,
    output logic [ebrf_pkg::DATA_W-1:0]  o_b_rdata,
    output ebrf_pkg::ebrf_flags_t        o_flags
);

    // ==================================================================
    // Storage
    localparam int DEPTH = 2 ** ebrf_pkg::ADDR_W;

    localparam ebrf_pkg::ebrf_state_t STATE_RST = '{
        a: '0, b: '0, push: '0, pop: '0,
        wptr: ebrf_pkg::PTR_RST, flags: ebrf_pkg::FLAGS_RST
    };

    ebrf_pkg::ebrf_word_t     mem [DEPTH];
    ebrf_pkg::ebrf_state_t    state_reg;
    ebrf_pkg::ebrf_state_t    state_next;
    ebrf_pkg::ebrf_port_out_t a_out_reg;
    ebrf_pkg::ebrf_port_out_t a_out_next;
    ebrf_pkg::ebrf_port_out_t b_out_reg;
    ebrf_pkg::ebrf_port_out_t b_out_next;
    ebrf_pkg::ebrf_ptr_t      rptr_reg;
    ebrf_pkg::ebrf_ptr_t      rptr_next;

    logic                     fifo;
    logic                     a_wr;
    logic                     a_rd;
    logic                     b_act;
    logic                     b_wr;
    logic                     b_rd;
    logic                     push_go;
    logic                     pop_go;
    logic                     rptr_clear;
    logic                     a_clr_async;
    logic                     b_clr_async;
    ebrf_pkg::ebrf_word_t     a_old;
    ebrf_pkg::ebrf_word_t     b_old;
    ebrf_pkg::ebrf_word_t     a_merge;
    ebrf_pkg::ebrf_word_t     b_merge;
    ebrf_pkg::ebrf_word_t     pop_word;
    ebrf_pkg::ebrf_ptr_t      full_lvl;
    ebrf_pkg::ebrf_ptr_t      afull_lvl;
    ebrf_pkg::ebrf_ptr_t      aempty_lvl;
    ebrf_pkg::ebrf_ptr_t      count_next;
    ebrf_pkg::ebrf_ptr_t      fifo_count;

    // ==================================================================
    // Helpers
    function automatic ebrf_pkg::ebrf_word_t lane_merge(
        input ebrf_pkg::ebrf_word_t               old_word,
        input ebrf_pkg::ebrf_word_t               new_word,
        input logic [ebrf_pkg::LANES-1:0]         mask
    );
        ebrf_pkg::ebrf_word_t w;
        w = old_word;
        for (int i = 0; i < ebrf_pkg::LANES; i++) begin
            if (mask[i]) begin
                w[i*ebrf_pkg::LANE_W +: ebrf_pkg::LANE_W] =
                    new_word[i*ebrf_pkg::LANE_W +: ebrf_pkg::LANE_W];
            end
        end
        return w;
    endfunction

    function automatic ebrf_pkg::ebrf_word_t port_latch(
        input ebrf_pkg::ebrf_wmode_t wmode,
        input logic                  rd,
        input logic                  wr,
        input ebrf_pkg::ebrf_word_t  old_word,
        input ebrf_pkg::ebrf_word_t  merged,
        input ebrf_pkg::ebrf_word_t  latch
    );
        ebrf_pkg::ebrf_word_t w;
        w = latch;
        if (rd) begin
            w = old_word;
        end else if (wr) begin
            unique case (wmode)
                ebrf_pkg::EBRF_WR_NORMAL:     w = latch;
                ebrf_pkg::EBRF_WR_THROUGH:    w = merged;
                ebrf_pkg::EBRF_WR_READ_FIRST: w = old_word;
                default:                      w = latch;
            endcase
        end
        return w;
    endfunction

    function automatic ebrf_pkg::ebrf_ptr_t clamp_level(
        input ebrf_pkg::ebrf_ptr_t v,
        input ebrf_pkg::ebrf_ptr_t lo,
        input ebrf_pkg::ebrf_ptr_t hi
    );
        ebrf_pkg::ebrf_ptr_t r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // ==================================================================
    // Decode of the captured requests
    assign fifo  = (i_cfg.mode == ebrf_pkg::EBRF_FIFO);
    assign a_wr  = state_reg.a.ce & state_reg.a.sel & state_reg.a.we & ~fifo;
    assign a_rd  = state_reg.a.ce & state_reg.a.sel & ~state_reg.a.we &
                   ((i_cfg.mode == ebrf_pkg::EBRF_SINGLE) |
                    (i_cfg.mode == ebrf_pkg::EBRF_TRUE_DUAL));
    assign b_act = state_reg.b.ce & state_reg.b.sel &
                   ((i_cfg.mode == ebrf_pkg::EBRF_TRUE_DUAL) |
                    (i_cfg.mode == ebrf_pkg::EBRF_PSEUDO_DUAL));
    assign b_wr  = b_act & state_reg.b.we & (i_cfg.mode == ebrf_pkg::EBRF_TRUE_DUAL);
    assign b_rd  = b_act & ~b_wr;

    // Cascade inputs are plain extra selects; flags block the side they guard
    assign push_go = fifo & state_reg.push.write_clock_enable & state_reg.push.push_enable &
                     state_reg.push.push_port_select & state_reg.push.full_cascade_input &
                     ~state_reg.flags.full_flag;
    assign pop_go  = fifo & state_reg.pop.read_clock_enable & state_reg.pop.pop_enable &
                     state_reg.pop.pop_port_select & state_reg.pop.empty_cascade_input &
                     ~state_reg.flags.empty_flag;

    assign a_old    = mem[state_reg.a.addr];
    assign b_old    = mem[state_reg.b.addr];
    assign pop_word = mem[rptr_reg[ebrf_pkg::ADDR_W-1:0]];
    assign a_merge  = lane_merge(a_old, state_reg.a.wdata, state_reg.a.byte_lane_mask);
    assign b_merge  = lane_merge(b_old, state_reg.b.wdata, state_reg.b.byte_lane_mask);

    // ==================================================================
    // Array; two ports collide only if software writes one address twice
    always_ff @(posedge i_mclk) begin
        if (i_ce) begin
            if (a_wr) begin
                mem[state_reg.a.addr] <= a_merge;
            end
            if (b_wr) begin
                mem[state_reg.b.addr] <= b_merge;
            end
            if (push_go) begin
                mem[state_reg.wptr[ebrf_pkg::ADDR_W-1:0]] <= state_reg.push.data;
            end
        end
    end

    // ==================================================================
    // Threshold limits
    assign full_lvl   = clamp_level(i_levels.full_level, ebrf_pkg::LEVEL_MIN,
                                    ebrf_pkg::LEVEL_MAX);
    assign afull_lvl  = clamp_level(i_levels.almost_full_level, ebrf_pkg::LEVEL_MIN,
                                    full_lvl - ebrf_pkg::LEVEL_MIN);
    assign aempty_lvl = clamp_level(i_levels.almost_empty_level, ebrf_pkg::LEVEL_MIN,
                                    full_lvl - ebrf_pkg::LEVEL_MIN);

    // ==================================================================
    // Main state
    assign rptr_next  = rptr_reg + ebrf_pkg::ebrf_ptr_t'(pop_go);
    assign count_next = state_next.wptr - rptr_next;
    assign fifo_count = state_reg.wptr - rptr_reg;

    always_comb begin
        state_next      = state_reg;
        state_next.a    = i_port_a;
        state_next.b    = i_port_b;
        state_next.push = i_push;
        state_next.pop  = i_pop;
        state_next.wptr = state_reg.wptr + ebrf_pkg::ebrf_ptr_t'(push_go);
        // Single clock here, so both flag pairs share it
        state_next.flags.full_flag         = (count_next >= full_lvl);
        state_next.flags.almost_full_flag  = (count_next >= afull_lvl);
        state_next.flags.empty_flag        = (count_next == ebrf_pkg::PTR_RST);
        state_next.flags.almost_empty_flag = (count_next <= aempty_lvl);
    end

    // Global reset is always live in FIFO mode and acts without the clock
    always_ff @(posedge i_mclk or posedge i_global_reset) begin
        if (i_global_reset) begin
            state_reg <= STATE_RST;
        end else if (i_rst) begin
            state_reg <= STATE_RST;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // Rewind leaves the write pointer alone so held data can be replayed
    assign rptr_clear = i_global_reset | i_read_pointer_rewind;

    always_ff @(posedge i_mclk or posedge rptr_clear) begin
        if (rptr_clear) begin
            rptr_reg <= ebrf_pkg::PTR_RST;
        end else if (i_rst) begin
            rptr_reg <= ebrf_pkg::PTR_RST;
        end else if (i_ce) begin
            rptr_reg <= rptr_next;
        end
    end

    // ==================================================================
    // Output latches and optional output registers
    always_comb begin
        a_out_next       = a_out_reg;
        a_out_next.latch = port_latch(i_cfg.wmode, a_rd, a_wr, a_old, a_merge,
                                      a_out_reg.latch);
        if (i_cfg.out_reg) begin
            a_out_next.dout = state_reg.a.output_register_enable ? a_out_reg.latch : a_out_reg.dout;
        end else begin
            a_out_next.dout = a_out_next.latch;
        end
        if (!ASYNC_LATCH_CLEAR && i_port_a_latch_clear) begin
            a_out_next = ebrf_pkg::OUT_RST;
        end
    end

    always_comb begin
        b_out_next = b_out_reg;
        if (fifo) begin
            b_out_next.latch = pop_go ? pop_word : b_out_reg.latch;
        end else begin
            b_out_next.latch = port_latch(i_cfg.wmode, b_rd, b_wr, b_old, b_merge,
                                          b_out_reg.latch);
        end
        if (i_cfg.out_reg) begin
            b_out_next.dout = (fifo ? state_reg.pop.output_read_enable : state_reg.b.output_register_enable) ?
                              b_out_reg.latch : b_out_reg.dout;
        end else begin
            b_out_next.dout = b_out_next.latch;
        end
        if (!ASYNC_LATCH_CLEAR && i_port_b_latch_clear) begin
            b_out_next = ebrf_pkg::OUT_RST;
        end
    end

    // Gating an async clear from logic is a glitch hazard; keep the inputs clean
    assign a_clr_async = i_global_reset | (ASYNC_LATCH_CLEAR & i_port_a_latch_clear);
    assign b_clr_async = i_global_reset | (ASYNC_LATCH_CLEAR & i_port_b_latch_clear);

    always_ff @(posedge i_mclk or posedge a_clr_async) begin
        if (a_clr_async) begin
            a_out_reg <= ebrf_pkg::OUT_RST;
        end else if (i_rst) begin
            a_out_reg <= ebrf_pkg::OUT_RST;
        end else if (i_ce) begin
            a_out_reg <= a_out_next;
        end
    end

    always_ff @(posedge i_mclk or posedge b_clr_async) begin
        if (b_clr_async) begin
            b_out_reg <= ebrf_pkg::OUT_RST;
        end else if (i_rst) begin
            b_out_reg <= ebrf_pkg::OUT_RST;
        end else if (i_ce) begin
            b_out_reg <= b_out_next;
        end
    end

    assign o_a_rdata = a_out_reg.dout;
    assign o_b_rdata = b_out_reg.dout;
    assign o_flags   = state_reg.flags;

    // ==================================================================
    // Assertions
    property p_input_capture;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset)
        i_ce && !i_global_reset |=> state_reg.a.addr == $past(i_port_a.addr) &&
                 state_reg.a.wdata == $past(i_port_a.wdata);
    endproperty
    a_input_capture: assert property (p_input_capture)
        else $error("port a request not captured");

    property p_bypass;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset)
        i_ce && !i_cfg.out_reg && !i_port_a_latch_clear |=> o_a_rdata == a_out_reg.latch;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypassed output differs from array latch");

    property p_normal_hold;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset)
        i_ce && a_wr && i_cfg.wmode == ebrf_pkg::EBRF_WR_NORMAL && !i_port_a_latch_clear
        |=> $stable(a_out_reg.latch);
    endproperty
    a_normal_hold: assert property (p_normal_hold)
        else $error("normal write changed the output latch");

    property p_write_through;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset)
        i_ce && a_wr && i_cfg.wmode == ebrf_pkg::EBRF_WR_THROUGH &&
        (&state_reg.a.byte_lane_mask) && !i_port_a_latch_clear
        |=> a_out_reg.latch == $past(state_reg.a.wdata);
    endproperty
    a_write_through: assert property (p_write_through)
        else $error("write-through word missing on output");

    property p_read_first;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset)
        i_ce && a_wr && i_cfg.wmode == ebrf_pkg::EBRF_WR_READ_FIRST && !i_port_a_latch_clear
        |=> a_out_reg.latch == $past(a_old);
    endproperty
    a_read_first: assert property (p_read_first)
        else $error("old word missing on read-before-write");

    property p_cascade;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset)
        i_ce && !state_reg.push.full_cascade_input |=> $stable(state_reg.wptr);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("push taken with cascade select low");

    property p_full_flag;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset || i_read_pointer_rewind)
        // The edge that still samples rewind high sees flags from the old pointer
        !i_read_pointer_rewind && $past(i_ce) && !$past(i_read_pointer_rewind) && $past(fifo)
        |-> o_flags.full_flag == (fifo_count >= $past(full_lvl));
    endproperty
    a_full_flag: assert property (p_full_flag)
        else $error("full flag does not match fill level");

    property p_empty_flag;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset || i_read_pointer_rewind)
        !i_read_pointer_rewind && $past(i_ce) && !$past(i_read_pointer_rewind)
        |-> o_flags.empty_flag == (fifo_count == ebrf_pkg::PTR_RST);
    endproperty
    a_empty_flag: assert property (p_empty_flag)
        else $error("empty flag does not match fill level");

    property p_no_push_full;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset)
        i_ce && o_flags.full_flag |=> $stable(state_reg.wptr);
    endproperty
    a_no_push_full: assert property (p_no_push_full)
        else $error("write pointer moved while full");

    property p_global_reset;
        @(posedge i_mclk) disable iff (i_rst)
        i_global_reset |-> state_reg.wptr == ebrf_pkg::PTR_RST &&
                           rptr_reg == ebrf_pkg::PTR_RST && o_flags.empty_flag &&
                           !o_flags.full_flag && o_a_rdata == ebrf_pkg::WORD_RST;
    endproperty
    a_global_reset: assert property (p_global_reset)
        else $error("global reset left state behind");

    property p_rewind;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset)
        i_read_pointer_rewind |-> rptr_reg == ebrf_pkg::PTR_RST;
    endproperty
    a_rewind: assert property (p_rewind)
        else $error("rewind did not clear read pointer");

    property p_latch_clear;
        @(posedge i_mclk) disable iff (i_rst || i_global_reset)
        i_ce && i_port_a_latch_clear |=> o_a_rdata == ebrf_pkg::WORD_RST &&
                                         a_out_reg.latch == ebrf_pkg::WORD_RST;
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("port a latch clear failed");

    c_fill: cover property (@(posedge i_mclk) disable iff (i_rst)
        $rose(o_flags.full_flag));
    c_drain: cover property (@(posedge i_mclk) disable iff (i_rst)
        $rose(o_flags.empty_flag) && !i_global_reset);
    c_rewind: cover property (@(posedge i_mclk) disable iff (i_rst)
        i_read_pointer_rewind && fifo_count != ebrf_pkg::PTR_RST);
    c_through: cover property (@(posedge i_mclk) disable iff (i_rst)
        a_wr && i_cfg.wmode == ebrf_pkg::EBRF_WR_THROUGH);

endmodule

/* pkg/ebrf_pkg.sv */
// Summary of operation
// - Port write data and address registered at input
// - Output register selectable or bypassed
// - Normal mode: output unchanged on writes
// - Write-through: written word appears on output
// - Read-before-write: old word appears on output
// - FIFO push side and pop side ports
// - Cascade inputs act as port selects
// - Full and almost-full registered on push side
// - Empty and almost-empty registered on pop side
// - Full threshold one to depth minus one
// - Almost thresholds one to full minus one
// - Global reset clears pointers and flags
// - Rewind resets only the read pointer
// - Latch clear synchronous or asynchronous
// - Local clears per port, global clears both
// - FIFO enables sequence around global reset
// - Global reset and rewind are asynchronous
// - Synchronous reset without global: no sequencing
// - Organisation set by word and address width
package ebrf_pkg;

    // ==================================================================
    // Sizes
    localparam int DATA_W = 18;
    localparam int ADDR_W = 9;
    localparam int LANE_W = 9;
    localparam int LANES  = 2;
    localparam int PTR_W  = ADDR_W + 1;

    typedef logic [DATA_W-1:0] ebrf_word_t;
    typedef logic [ADDR_W-1:0] ebrf_addr_t;
    typedef logic [PTR_W-1:0]  ebrf_ptr_t;

    // ==================================================================
    // Reset values and level limits
    localparam ebrf_word_t WORD_RST  = 18'h00000;
    localparam ebrf_ptr_t  PTR_RST   = 10'h000;
    localparam ebrf_ptr_t  LEVEL_MIN = 10'h001;
    localparam ebrf_ptr_t  LEVEL_MAX = 10'h1ff;

    // ==================================================================
    // Modes
    typedef enum logic [1:0] {
        EBRF_SINGLE, EBRF_TRUE_DUAL, EBRF_PSEUDO_DUAL, EBRF_FIFO
    } ebrf_mode_t;

    typedef enum logic [1:0] {
        EBRF_WR_NORMAL, EBRF_WR_THROUGH, EBRF_WR_READ_FIRST
    } ebrf_wmode_t;

    // ==================================================================
    // Carriers
    typedef struct packed {
        ebrf_mode_t  mode;
        ebrf_wmode_t wmode;
        logic        out_reg;
    } ebrf_cfg_t;

    typedef struct packed {
        logic             ce;
        logic             output_register_enable;
        logic             sel;
        logic             we;
        logic [LANES-1:0] byte_lane_mask;
        ebrf_addr_t       addr;
        ebrf_word_t       wdata;
    } ebrf_port_req_t;

    typedef struct packed {
        logic       write_clock_enable;
        logic       push_enable;
        logic       push_port_select;
        logic       full_cascade_input;
        ebrf_word_t data;
    } ebrf_push_req_t;

    typedef struct packed {
        logic read_clock_enable;
        logic pop_enable;
        logic pop_port_select;
        logic empty_cascade_input;
        logic output_read_enable;
    } ebrf_pop_req_t;

    typedef struct packed {
        ebrf_ptr_t full_level;
        ebrf_ptr_t almost_full_level;
        ebrf_ptr_t almost_empty_level;
    } ebrf_levels_t;

    typedef struct packed {
        logic full_flag;
        logic almost_full_flag;
        logic almost_empty_flag;
        logic empty_flag;
    } ebrf_flags_t;

    localparam ebrf_flags_t FLAGS_RST = 4'h3;

    typedef struct packed {
        ebrf_word_t latch;
        ebrf_word_t dout;
    } ebrf_port_out_t;

    localparam ebrf_port_out_t OUT_RST = 36'h000000000;

    typedef struct packed {
        ebrf_port_req_t a;
        ebrf_port_req_t b;
        ebrf_push_req_t push;
        ebrf_pop_req_t  pop;
        ebrf_ptr_t      wptr;
        ebrf_flags_t    flags;
    } ebrf_state_t;

endpackage

/* bench/ebrf_fabric_model.sv */
`timescale 1ns/10ps
module ebrf_fabric_model (
    input  wire logic                    i_mclk,
    output ebrf_pkg::ebrf_push_req_t     o_push,
    output ebrf_pkg::ebrf_pop_req_t      o_pop,
    output logic                         o_global_reset,
    output logic                         o_read_pointer_rewind
);
    // ==================================================================
    // Fabric side: all controls active high, changed right after an edge
    initial begin
        o_push = '0;
        o_pop = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        o_global_reset = 1'b0;
        o_read_pointer_rewind = 1'b0;
    end

    // Cascade low must refuse the push like a deselected port
    task automatic push(input ebrf_pkg::ebrf_word_t d, input logic casc);
        @(posedge i_mclk);
        o_push <= '{1'b1, 1'b1, 1'b1, casc, d};
        @(posedge i_mclk);
        o_push <= '{1'b0, 1'b0, 1'b0, 1'b0, ~d};
    endtask

    // Stall lets the consumer answer slowly
    task automatic pop(input int stall);
        repeat (stall) @(posedge i_mclk);
        @(posedge i_mclk);
        o_pop <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        @(posedge i_mclk);
        o_pop <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    endtask

    // Enables idle one cycle before and after, since the reset is asynchronous
    task automatic async_pulse(input bit rewind);
        @(posedge i_mclk);
        @(posedge i_mclk);
        if (rewind) o_read_pointer_rewind <= 1'b1;
        else o_global_reset <= 1'b1;
        @(posedge i_mclk);
        o_read_pointer_rewind <= 1'b0;
        o_global_reset <= 1'b0;
        @(posedge i_mclk);
    endtask
endmodule

/* bench/tb_embedded_block_ram_fifo.sv */
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_embedded_block_ram_fifo;
    logic                     mclk, rst, ce, clr_a, clr_b;
    ebrf_pkg::ebrf_cfg_t      cfg;
    ebrf_pkg::ebrf_port_req_t pa, pb;
    ebrf_pkg::ebrf_levels_t   levels;
    ebrf_pkg::ebrf_push_req_t push;
    ebrf_pkg::ebrf_pop_req_t  pop;
    ebrf_pkg::ebrf_flags_t    flags;
    logic [17:0]              a_rd, b_rd;
    logic                     grst, rew;
    int                       error_cnt, cmp_count;

    ebrf_block_memory ebrf_block_memory_inst (.i_mclk(mclk), .i_rst(rst), .i_ce(ce),
        .i_cfg(cfg), .i_port_a(pa), .i_port_b(pb), .i_port_a_latch_clear(clr_a),
        .i_port_b_latch_clear(clr_b), .i_push(push), .i_pop(pop), .i_levels(levels),
        .i_global_reset(grst), .i_read_pointer_rewind(rew), .o_a_rdata(a_rd),
        .o_b_rdata(b_rd), .o_flags(flags));
    ebrf_fabric_model ebrf_fabric_model_inst (.i_mclk(mclk), .o_push(push), .o_pop(pop),
        .o_global_reset(grst), .o_read_pointer_rewind(rew));

    // ==================================================================
    // Clock, closing and watchdog
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic conclude;
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        error_cnt++;
        conclude();
    end

    // ==================================================================
    // Helpers
    function automatic ebrf_pkg::ebrf_flags_t exp_flags(input int n);
        return {n >= 4, n >= 3, n <= 1, n == 0};
    endfunction
    task automatic set_cfg(input ebrf_pkg::ebrf_mode_t m, input ebrf_pkg::ebrf_wmode_t w,
                           input logic o);
        @(posedge mclk);
        cfg <= '{m, w, o};
    endtask
    // Request driven at the next edge, captured one edge later, performed the edge after that, checked after it
    task automatic access(input bit on_b, input logic we, input logic [1:0] mask,
                          input ebrf_pkg::ebrf_addr_t ad, input ebrf_pkg::ebrf_word_t wd);
        ebrf_pkg::ebrf_port_req_t r;
        r = '{1'b1, 1'b1, 1'b1, we, mask, ad, wd};
        @(posedge mclk);
        if (on_b) pb <= r;
        else pa <= r;
        @(posedge mclk);
        r.ce = 1'b0;
        r.we = 1'b0;
        r.wdata = ~wd;
        pa <= r;
        pb <= r;
        @(posedge mclk);
        #1;
    endtask

    // ==================================================================
    // Tests
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        clr_a = 1'b0;
        clr_b = 1'b0;
        cfg = '{ebrf_pkg::EBRF_SINGLE, ebrf_pkg::EBRF_WR_NORMAL, 1'b0};
        pa = '0;
        pb = '0;
        levels = '{10'h004, 10'h003, 10'h001};
        error_cnt = 0;
        cmp_count = 0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        access(0, 1'b1, 2'b11, 9'h005, 18'h2a5a5);
        `CHK(a_rd, 18'h00000);
        access(0, 1'b0, 2'b11, 9'h005, 18'h00000);
        `CHK(a_rd, 18'h2a5a5);
        set_cfg(ebrf_pkg::EBRF_SINGLE, ebrf_pkg::EBRF_WR_THROUGH, 1'b0);
        access(0, 1'b1, 2'b01, 9'h005, 18'h3ffff);
        `CHK(a_rd, 18'h2a5ff);
        set_cfg(ebrf_pkg::EBRF_SINGLE, ebrf_pkg::EBRF_WR_READ_FIRST, 1'b0);
        access(0, 1'b1, 2'b11, 9'h005, 18'h00111);
        `CHK(a_rd, 18'h2a5ff);
        set_cfg(ebrf_pkg::EBRF_SINGLE, ebrf_pkg::EBRF_WR_NORMAL, 1'b1);
        access(0, 1'b1, 2'b11, 9'h007, 18'h15555);
        access(0, 1'b0, 2'b11, 9'h007, 18'h00000);
        `CHK(a_rd, 18'h2a5ff);
        @(posedge mclk);
        #1;
        `CHK(a_rd, 18'h15555);
        @(posedge mclk) ce <= 1'b0;
        access(0, 1'b0, 2'b11, 9'h005, 18'h00000);
        `CHK(a_rd, 18'h15555);
        @(posedge mclk) ce <= 1'b1;
        set_cfg(ebrf_pkg::EBRF_TRUE_DUAL, ebrf_pkg::EBRF_WR_NORMAL, 1'b0);
        access(1, 1'b0, 2'b11, 9'h007, 18'h00000);
        `CHK(b_rd, 18'h15555);
        @(posedge mclk) clr_a <= 1'b1;
        @(posedge mclk) clr_a <= 1'b0;
        #1;
        `CHK(a_rd, 18'h00000);
        `CHK(b_rd, 18'h15555);
        @(posedge mclk) clr_b <= 1'b1;
        @(posedge mclk) clr_b <= 1'b0;
        #1;
        `CHK(b_rd, 18'h00000);
        set_cfg(ebrf_pkg::EBRF_FIFO, ebrf_pkg::EBRF_WR_NORMAL, 1'b0);
        ebrf_fabric_model_inst.push(18'h12345, 1'b0);
        @(posedge mclk);
        #1;
        `CHK(flags, exp_flags(0));
        for (int i = 0; i < 5; i++) begin
            ebrf_fabric_model_inst.push(18'h2b000 + 18'(i), 1'b1);
            @(posedge mclk);
            #1;
            `CHK(flags, exp_flags(i < 4 ? i + 1 : 4));
        end
        for (int i = 0; i < 5; i++) begin
            ebrf_fabric_model_inst.pop(i == 2 ? 3 : 0);
            @(posedge mclk);
            #1;
            `CHK(b_rd, 18'h2b000 + 18'(i < 4 ? i : 3));
            `CHK(flags, exp_flags(i < 4 ? 3 - i : 0));
        end
        ebrf_fabric_model_inst.async_pulse(1'b1);
        #1;
        `CHK(flags, exp_flags(4));
        ebrf_fabric_model_inst.pop(0);
        @(posedge mclk);
        #1;
        `CHK(b_rd, 18'h2b000);
        fork
            ebrf_fabric_model_inst.async_pulse(1'b0);
            begin
                repeat (2) @(posedge mclk);
                #1;
                `CHK(flags, ebrf_pkg::FLAGS_RST);
                `CHK(b_rd, 18'h00000);
            end
        join
        conclude();
    end
endmodule
